// ==== rtl/cspl_status_pins.v ====
// Charger control and status pin logic: wake button, alert, status pins.
//
// Overview of operation
// - Wake button reads high by default through an internal weak pull-up.
// - In ship mode the battery switch stays open.
// - Button low for the ship exit press time leaves ship mode.
// - Without input, a long press opens the switch 320ms then recloses.
// - Each status event gives one 256us low alert pulse, up to four queued.
// - Source select high gives 500mA default limit, low gives 2.4A.
// - A host-written limit field replaces the source-select default.
// - Input-good goes low only when every input condition is good.
// - Charge-state pin is held low while charging.
// - Charge-state pin released when done or in sleep.
// - Charge-state pin blinks at 1Hz, 50% duty, on fault suspend.
// - A two-bit function select can disable the charge-state pin.
// - Direct-charge enable output goes high when commanded.
// - Each USB data line level comes from its own two-bit field.
// - Charging only when config bit is 1 and enable input is low.
//
// Implementation choices: the plain strobed port and the register addresses.
`timescale 1ns/1ns
`include "cspl_map.vh"
module cspl_status_pins #(
  parameter SHIP_EXIT_CYC  = (`CSPL_CLK_HZ / 1000) * `CSPL_SHIP_EXIT_MS,
  parameter FULL_RST_CYC   = (`CSPL_CLK_HZ / 1000) * `CSPL_FULL_RESET_MS,
  parameter SW_OFF_CYC     = (`CSPL_CLK_HZ / 1000) * `CSPL_SWITCH_OFF_MS,
  parameter BLINK_HALF_CYC = (`CSPL_CLK_HZ / 1000) * `CSPL_BLINK_HALF_MS,
  parameter ALERT_CYC      = (`CSPL_CLK_HZ / 1000000) * `CSPL_ALERT_US
) (
  input  wire        clk_sys_i,
  input  wire        nrst_i,
  input  wire [3:0]  addr_i,
  input  wire [7:0]  wdata_i,
  input  wire        wr_i,
  input  wire        rd_i,
  output reg  [7:0]  rdata_o,
  input  wire        ship_wake_button_n_i,
  output wire        ship_wake_pullup_en_o,
  input  wire        input_present_i,
  input  wire        battery_present_i,
  input  wire        above_uvlo_i,
  input  wire        below_ovp_i,
  input  wire        above_sleep_i,
  input  wire        charging_i,
  input  wire        charge_done_i,
  input  wire        fault_suspend_i,
  input  wire        status_event_i,
  input  wire        source_select_i,
  input  wire        charge_enable_n_i,
  output reg         battery_switch_on_o,
  output wire        host_alert_n_o,
  output wire        host_alert_n_oe_n_o,
  output wire        input_good_n_o,
  output wire        input_good_n_oe_n_o,
  output wire        charge_state_o,
  output wire        charge_state_oe_n_o,
  output reg         direct_charge_enable_out_o,
  output reg  [4:0]  input_current_limit_o,
  output reg         charge_allow_o,
  output reg  [1:0]  dplus_level_select_o,
  output reg  [1:0]  dminus_level_select_o
);
  // Switch states.
  localparam ST_ON   = 2'd0;
  localparam ST_SHIP = 2'd1;
  localparam ST_RST  = 2'd2;

  // Events that may queue up behind a running alert pulse.
  localparam QW = 4;

  reg [7:0]  ctrl_q;
  reg [7:0]  icl_q;
  reg [7:0]  level_q;
  reg [1:0]  sw_st_q;
  reg [1:0]  sw_st_d;
  reg [27:0] press_q;
  reg [27:0] off_q;
  reg        press_done_q;
  reg        ship_sync1_q;
  reg        ship_sync2_q;
  reg        btn_q;
  reg [3:0]  deb_q;
  reg [24:0] blink_q;
  reg        blink_lvl_q;
  reg [QW-1:0] pend_q;
  reg        fault_sync1_q;
  reg        fault_sync2_q;
  reg        evt_sync1_q;
  reg        evt_sync2_q;
  reg        evt_seen_q;
  reg [7:0]  evt_cnt_q;
  wire       alert_busy;
  wire       alert_done;
  wire       alert_start;
  wire       evt_rise;

  // Saturating increment used by the event counter path only.
  function [7:0] sat_inc;
    input [7:0] v;
    begin
      sat_inc = (v == 8'hff) ? v : v + 8'h01;
    end
  endfunction

  // Internal pull-up
  // The pull-up is only powered while some supply exists.
  assign ship_wake_pullup_en_o = input_present_i | battery_present_i;

  // Button synchroniser
  // Two flops first, then a short debounce; the counters reject any glitch
  // shorter than the exit press time anyway.
  always @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      ship_sync1_q <= 1'b1;
      ship_sync2_q <= 1'b1;
      deb_q        <= 4'h0;
      btn_q        <= 1'b1;
      evt_sync1_q  <= 1'b0;
      evt_sync2_q  <= 1'b0;
      fault_sync1_q <= 1'b0;
      fault_sync2_q <= 1'b0;
      evt_seen_q   <= 1'b0;
    end
    else
    begin
      ship_sync1_q <= ship_wake_button_n_i;
      ship_sync2_q <= ship_sync1_q;
      evt_sync1_q  <= status_event_i;
      evt_sync2_q  <= evt_sync1_q;
      fault_sync1_q <= fault_suspend_i;
      fault_sync2_q <= fault_sync1_q;
      evt_seen_q   <= evt_sync2_q;
      if (ship_sync2_q == btn_q)
        deb_q <= 4'h0;
      else if (deb_q == 4'hf)
      begin
        btn_q <= ship_sync2_q;
        deb_q <= 4'h0;
      end
      else
        deb_q <= deb_q + 4'h1;
    end
  end

  assign evt_rise = evt_sync2_q & ~evt_seen_q;

  // Press duration counter
  // Counts debounced low time; saturates so a held button cannot wrap.
  always @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      press_q      <= 28'h0000000;
      press_done_q <= 1'b0;
    end
    else if (btn_q)
    begin
      press_q      <= 28'h0000000;
      press_done_q <= 1'b0;
    end
    else
    begin
      if (press_q != 28'hfffffff)
        press_q <= press_q + 28'h0000001;
      if (sw_st_q == ST_RST)
        press_done_q <= 1'b1;
    end
  end

  // Switch state machine: ship mode, wake, and full power reset.
  always @*
  begin
    sw_st_d = sw_st_q;
    case (sw_st_q)
      ST_ON:
      begin
        if (ctrl_q[`CSPL_CTRL_SHIPREQ])
          sw_st_d = ST_SHIP;
        else if (!input_present_i && !press_done_q &&
                 press_q >= FULL_RST_CYC[27:0])
          sw_st_d = ST_RST;
      end
      ST_SHIP:
      begin
        if (press_q >= SHIP_EXIT_CYC[27:0])
          sw_st_d = ST_ON;
      end
      ST_RST:
      begin
        if (off_q >= SW_OFF_CYC[27:0] - 28'h0000001)
          sw_st_d = ST_ON;
      end
      default:
        sw_st_d = ST_ON;
    endcase
  end

  // State register, off-interval counter and the switch drive.
  always @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      sw_st_q             <= ST_ON;
      off_q               <= 28'h0000000;
      battery_switch_on_o <= 1'b1;
    end
    else
    begin
      sw_st_q <= sw_st_d;
      if (sw_st_q == ST_RST)
        off_q <= off_q + 28'h0000001;
      else
        off_q <= 28'h0000000;
      battery_switch_on_o <= (sw_st_d == ST_ON);
    end
  end

  // Event queue
  // A thermometer count of events still owed a pulse; one is taken as a
  // pulse starts. A saturated queue drops further events rather than merge.
  always @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
      pend_q <= {QW{1'b0}};
    else if (evt_rise && !alert_start)
      pend_q <= {pend_q[QW-2:0], 1'b1};
    else if (!evt_rise && alert_start)
      pend_q <= {1'b0, pend_q[QW-1:1]};
  end

  // Alert start
  // A two-cycle gap after each pulse keeps back-to-back pulses distinct.
  assign alert_start = pend_q[0] & ~alert_busy & ~alert_done;

  // Pulse timer; its done flag holds off the next start for one cycle.

  cspl_pulse_timer #(
    .CNT_W (13)
  ) u_alert (
    .clk_sys_i (clk_sys_i),
    .nrst_i    (nrst_i),
    .start_i   (alert_start),
    .length_i  (ALERT_CYC[12:0]),
    .busy_o    (alert_busy),
    .done_o    (alert_done)
  );

  assign host_alert_n_o      = 1'b0;
  assign host_alert_n_oe_n_o = ~alert_busy;

  assign input_good_n_o      = 1'b0;
  assign input_good_n_oe_n_o = ~(above_uvlo_i & below_ovp_i & above_sleep_i &
                                 (input_current_limit_o != 5'h00));

  // Blink timer
  // Free-running half-period counter; restarted outside fault so each
  // blink sequence begins with a full low half.
  always @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      blink_q     <= 25'h0000000;
      blink_lvl_q <= 1'b0;
    end
    else if (!fault_sync2_q)
    begin
      blink_q     <= 25'h0000000;
      blink_lvl_q <= 1'b0;
    end
    else if (blink_q == BLINK_HALF_CYC[24:0] - 25'h0000001)
    begin
      blink_q     <= 25'h0000000;
      blink_lvl_q <= ~blink_lvl_q;
    end
    else
      blink_q <= blink_q + 25'h0000001;
  end

  // Charge state drive
  // Released when done or asleep, low while charging, blinking on fault.
  // Released when done
  assign charge_state_o      = 1'b0;
  assign charge_state_oe_n_o =
    (ctrl_q[`CSPL_CTRL_FSEL_LO+1:`CSPL_CTRL_FSEL_LO] == `CSPL_FSEL_DISABLE) ?
      1'b1 :
    fault_sync2_q ? blink_lvl_q :
    (charging_i && !charge_done_i) ? 1'b0 : 1'b1;

  // Register writes; the limit register keeps only its low five bits plus a valid flag.
  always @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      ctrl_q    <= `CSPL_CTRL_RESET;
      icl_q     <= `CSPL_ICL_RESET;
      level_q   <= `CSPL_LEVEL_RESET;
      evt_cnt_q <= 8'h00;
    end
    else
    begin
      if (wr_i && addr_i == `CSPL_REG_CTRL)
        ctrl_q <= wdata_i;
      else if (sw_st_q == ST_SHIP)
        ctrl_q[`CSPL_CTRL_SHIPREQ] <= 1'b0;
      if (wr_i && addr_i == `CSPL_REG_ICL)
        icl_q <= {2'b00, 1'b1, wdata_i[4:0]};
      if (wr_i && addr_i == `CSPL_REG_LEVEL)
        level_q <= wdata_i;
      // Event tally: the set wins over a clearing write.
      if (evt_rise)
        evt_cnt_q <= sat_inc(evt_cnt_q);
      else if (wr_i && addr_i == `CSPL_REG_EVENT)
        evt_cnt_q <= 8'h00;
    end
  end

  // Registered pin and limit outputs.
  always @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      direct_charge_enable_out_o <= 1'b0;
      input_current_limit_o      <= `CSPL_ICL_500MA;
      charge_allow_o             <= 1'b0;
      dplus_level_select_o       <= 2'b00;
      dminus_level_select_o      <= 2'b00;
    end
    else
    begin
      direct_charge_enable_out_o <= ctrl_q[`CSPL_CTRL_DIRECT_CHARGE_ENABLE_OUT];
      if (icl_q[`CSPL_ICL_VALID])
        input_current_limit_o <= icl_q[4:0];
      else if (source_select_i)
        input_current_limit_o <= `CSPL_ICL_500MA;
      else
        input_current_limit_o <= `CSPL_ICL_2400MA;
      charge_allow_o <= ctrl_q[`CSPL_CTRL_CHGCFG] & ~charge_enable_n_i;
      dplus_level_select_o  <= level_q[1:0];
      dminus_level_select_o <= level_q[3:2];
    end
  end

  // Read port: data one cycle after the strobe, zero otherwise.
  always @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
      rdata_o <= 8'h00;
    else if (rd_i)
    begin
      case (addr_i)
        `CSPL_REG_CTRL:   rdata_o <= ctrl_q;
        `CSPL_REG_ICL:    rdata_o <= icl_q;
        `CSPL_REG_LEVEL:  rdata_o <= level_q;
        `CSPL_REG_STATUS: rdata_o <= {2'b00, sw_st_q, alert_busy,
                                      ~input_good_n_oe_n_o,
                                      battery_switch_on_o, charge_allow_o};
        `CSPL_REG_EVENT:  rdata_o <= evt_cnt_q;
        default:          rdata_o <= 8'h00;
      endcase
    end
    else
      rdata_o <= 8'h00;
  end
endmodule

// ==== rtl/cspl_map.vh ====
// Register offsets, field positions, reset values and timing counts.
`ifndef CSPL_MAP_VH
`define CSPL_MAP_VH
`define CSPL_ADDR_W          4
`define CSPL_REG_CTRL        4'h0
`define CSPL_REG_ICL         4'h1
`define CSPL_REG_LEVEL       4'h2
`define CSPL_REG_STATUS      4'h3
`define CSPL_REG_EVENT       4'h4
`define CSPL_CTRL_CHGCFG     0
`define CSPL_CTRL_DIRECT_CHARGE_ENABLE_OUT       1
`define CSPL_CTRL_SHIPREQ    2
`define CSPL_CTRL_FSEL_LO    4
`define CSPL_CTRL_RESET      8'h01
`define CSPL_ICL_VALID       5
`define CSPL_ICL_RESET       8'h00
`define CSPL_LEVEL_RESET     8'h00
`define CSPL_FSEL_DISABLE    2'b00
`define CSPL_ICL_500MA       5'h04
`define CSPL_ICL_2400MA      5'h17
`define CSPL_CLK_HZ          20000000
`define CSPL_SHIP_EXIT_MS    1000
`define CSPL_FULL_RESET_MS   10000
`define CSPL_SWITCH_OFF_MS   320
`define CSPL_ALERT_US        256
`define CSPL_BLINK_HALF_MS   500
`endif

// ==== rtl/cspl_pulse_timer.v ====
// Down-counter that holds its output high for a programmed number of cycles.
`timescale 1ns/1ns
module cspl_pulse_timer #(
  parameter CNT_W = 24
) (
  input  wire             clk_sys_i,
  input  wire             nrst_i,
  input  wire             start_i,
  input  wire [CNT_W-1:0] length_i,
  output wire             busy_o,
  output reg              done_o
);
  reg [CNT_W-1:0] cnt_q;

  // A start while busy is ignored; the caller queues it instead.
  always @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      cnt_q  <= {CNT_W{1'b0}};
      done_o <= 1'b0;
    end
    else
    begin
      done_o <= (cnt_q == {{(CNT_W-1){1'b0}}, 1'b1});
      if (start_i && cnt_q == {CNT_W{1'b0}})
        cnt_q <= length_i;
      else if (cnt_q != {CNT_W{1'b0}})
        cnt_q <= cnt_q - {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

  assign busy_o = (cnt_q != {CNT_W{1'b0}});
endmodule

// ==== verif/cspl_status_pins_monitor.sv ====
// Port-level checker for the charger status pin block.
`timescale 1ns/1ns
`include "cspl_map.vh"
module cspl_status_pins_monitor #(
  parameter ALERT_CYC = 16
) (
  input wire       clk_sys_i,
  input wire       nrst_i,
  input wire [3:0] addr_i,
  input wire [7:0] wdata_i,
  input wire       wr_i,
  input wire       ship_wake_pullup_en_o,
  input wire       input_present_i,
  input wire       battery_present_i,
  input wire       above_uvlo_i,
  input wire       below_ovp_i,
  input wire       above_sleep_i,
  input wire       charging_i,
  input wire       fault_suspend_i,
  input wire       charge_enable_n_i,
  input wire       host_alert_n_oe_n_o,
  input wire       input_good_n_oe_n_o,
  input wire       charge_state_oe_n_o,
  input wire       direct_charge_enable_out_o,
  input wire [4:0] input_current_limit_o,
  input wire       charge_allow_o,
  input wire [1:0] dplus_level_select_o,
  input wire [1:0] dminus_level_select_o
);
  reg [15:0] low_q;

  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);

  // Counts how long the alert line has been pulled; cleared when released.
  always @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
      low_q <= 16'h0;
    else if (!host_alert_n_oe_n_o)
      low_q <= low_q + 16'h1;
    else
      low_q <= 16'h0;
  end

  a_pullup_source: assert property (
    ship_wake_pullup_en_o == (input_present_i | battery_present_i))
    else $error("button pull-up enable wrong");
  a_good_only_if: assert property (
    !input_good_n_oe_n_o |-> above_uvlo_i && below_ovp_i && above_sleep_i
    && input_current_limit_o != 5'h00) else $error("input good too early");
  a_good_when_all: assert property (
    above_uvlo_i && below_ovp_i && above_sleep_i
    && input_current_limit_o != 5'h00 |-> !input_good_n_oe_n_o)
    else $error("input good missing");
  a_alert_width: assert property (
    $rose(host_alert_n_oe_n_o) |-> low_q == ALERT_CYC)
    else $error("alert pulse length wrong");
  a_direct_charge_enable_out_write: assert property (
    wr_i && addr_i == `CSPL_REG_CTRL |-> ##2 {7'h00,
    direct_charge_enable_out_o} == (($past(wdata_i, 2) >> 1) & 8'h01))
    else $error("direct charge out wrong");
  a_level_write: assert property (
    wr_i && addr_i == `CSPL_REG_LEVEL |-> ##2 {4'h0, dminus_level_select_o,
    dplus_level_select_o} == ($past(wdata_i, 2) & 8'h0f))
    else $error("data line level wrong");
  a_allow_needs_pin: assert property (
    $past(charge_enable_n_i) |-> !charge_allow_o)
    else $error("charging allowed with enable high");
  a_state_released: assert property (
    !charging_i && !$past(charging_i) && !fault_suspend_i
    && !$past(fault_suspend_i) && !$past(fault_suspend_i, 2)
    && !$past(fault_suspend_i, 3) |-> charge_state_oe_n_o)
    else $error("charge state pin pulled when idle");
endmodule

// ==== verif/cspl_host_model.sv ====
// Host side model: pull-ups on the open-drain lines and the push button.
`timescale 1ns/1ns
module cspl_host_model (
  input  wire        clk_sys_i,
  input  wire        press_i,
  input  wire        alert_oe_n_i,
  input  wire        alert_i,
  input  wire        good_oe_n_i,
  input  wire        good_i,
  input  wire        state_oe_n_i,
  input  wire        state_i,
  output wire        button_n_o,
  output wire        alert_line_o,
  output wire        good_line_o,
  output wire        state_line_o,
  output reg  [7:0]  pulses_o,
  output reg  [15:0] width_o
);
  reg [15:0] run_q;

  // Button hold
  // A closed button shorts the line; otherwise the pull-up holds it high.
  assign button_n_o = !press_i;
  // Released open-drain lines read high through the board pull-ups.
  assign alert_line_o = alert_oe_n_i ? 1'b1 : alert_i;
  assign good_line_o  = good_oe_n_i ? 1'b1 : good_i;
  assign state_line_o = state_oe_n_i ? 1'b1 : state_i;

  initial
  begin
    pulses_o = 8'h00;
    width_o  = 16'h0;
    run_q    = 16'h0;
  end

  // The host counts alert pulses and keeps the width of the last one.
  always @(posedge clk_sys_i)
  begin
    if (!alert_line_o)
      run_q <= run_q + 16'h1;
    else if (run_q != 16'h0)
    begin
      width_o  <= run_q;
      pulses_o <= pulses_o + 8'h1;
      run_q    <= 16'h0;
    end
  end
endmodule

// ==== verif/test_cspl_status_pins.sv ====
// Self-checking bench for the charger status pin block.
`timescale 1ns/1ns
`include "cspl_map.vh"
module test_cspl_status_pins;
  localparam BLINK = 20;
  localparam SW_OFF = 50;
  reg clk_sys_i = 1'b0, nrst_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0, press = 1'b0;
  reg [3:0] addr_i = 4'h0;
  reg [7:0] wdata_i = 8'h00;
  reg input_present_i = 1'b1, battery_present_i = 1'b1, above_uvlo_i = 1'b1;
  reg below_ovp_i = 1'b1, above_sleep_i = 1'b1, charging_i = 1'b0;
  reg charge_done_i = 1'b0, fault_suspend_i = 1'b0, status_event_i = 1'b0;
  reg source_select_i = 1'b1, charge_enable_n_i = 1'b1, rd_seen = 1'b0;
  wire [7:0] rdata_o, pulses;
  wire [15:0] width;
  wire [4:0] input_current_limit_o;
  wire [1:0] dplus_level_select_o, dminus_level_select_o;
  wire ship_wake_button_n_i, ship_wake_pullup_en_o, battery_switch_on_o;
  wire host_alert_n_o, host_alert_n_oe_n_o, input_good_n_o;
  wire input_good_n_oe_n_o, charge_state_o, charge_state_oe_n_o;
  wire direct_charge_enable_out_o, charge_allow_o, alert_l, good_l, state_l;
  integer n_errors = 0, checks_done = 0, cyc = 0, i, k;
  reg [31:0] seed = 32'd79;
  reg [7:0] exp_q[$];

  cspl_status_pins #(.SHIP_EXIT_CYC(200), .FULL_RST_CYC(400),
    .SW_OFF_CYC(SW_OFF), .BLINK_HALF_CYC(BLINK), .ALERT_CYC(16))
    u_cspl_status_pins (.*);
  cspl_host_model u_cspl_host_model (.clk_sys_i(clk_sys_i), .press_i(press),
    .alert_oe_n_i(host_alert_n_oe_n_o), .alert_i(host_alert_n_o),
    .good_oe_n_i(input_good_n_oe_n_o), .good_i(input_good_n_o),
    .state_oe_n_i(charge_state_oe_n_o), .state_i(charge_state_o),
    .button_n_o(ship_wake_button_n_i), .alert_line_o(alert_l),
    .good_line_o(good_l), .state_line_o(state_l), .pulses_o(pulses),
    .width_o(width));

  always #25 clk_sys_i = ~clk_sys_i;

  function [31:0] xs(input [31:0] s);
    reg [31:0] t;
    begin
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
    end
  endfunction

  task chk(input [15:0] seen, input [15:0] exp);
    begin
      checks_done = checks_done + 1;
      if (seen !== exp)
      begin
        n_errors = n_errors + 1;
        $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask

  task wrap_up;
    begin
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask

  task tick(input integer n);
    repeat (n) @(posedge clk_sys_i) #1;
  endtask

  task wr(input [3:0] a, input [7:0] d);
    begin
      @(posedge clk_sys_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clk_sys_i);
      wr_i <= 1'b0;
      #1;
    end
  endtask

  // Each read notes its expected data; the watcher below compares it.
  task rd(input [3:0] a, input [7:0] e);
    begin
      exp_q.push_back(e);
      @(posedge clk_sys_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_sys_i);
      rd_i <= 1'b0;
      tick(1);
    end
  endtask

  // Bounded wait for the battery switch; k returns the cycles spent.
  task wait_sw(input v);
    for (k = 0; battery_switch_on_o !== v && k < 1000; k = k + 1)
      tick(1);
  endtask

  // Read data stand only in the cycle after the strobe.
  always @(posedge clk_sys_i)
    rd_seen <= rd_i;
  always @(negedge clk_sys_i)
    if (rd_seen)
      chk(rdata_o, exp_q.pop_front());

  // Cuts a hang short well past the expected length of the run.
  always @(posedge clk_sys_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_errors = n_errors + 1;
      wrap_up;
    end
  end

  initial
  begin
    tick(10);
    nrst_i <= 1'b1;
    tick(2);
    chk(input_current_limit_o, 5'h04);
    source_select_i <= 1'b0;
    tick(2);
    chk(input_current_limit_o, 5'h17);
    rd(`CSPL_REG_CTRL, `CSPL_CTRL_RESET);
    wr(`CSPL_REG_ICL, 8'h0a);
    tick(1);
    chk(input_current_limit_o, 5'h0a);
    rd(`CSPL_REG_ICL, 8'h2a);
    rd(4'hf, 8'h00);
    charge_enable_n_i <= 1'b0;
    wr(`CSPL_REG_CTRL, 8'h13);
    tick(2);
    chk(direct_charge_enable_out_o, 1'b1);
    chk(charge_allow_o, 1'b1);
    wr(`CSPL_REG_CTRL, 8'h12);
    tick(2);
    chk(charge_allow_o, 1'b0);
    for (i = 0; i < 4; i = i + 1)
    begin
      seed = xs(seed);
      wr(`CSPL_REG_LEVEL, {4'h0, seed[1:0], i[1:0]});
      tick(1);
      chk({dminus_level_select_o, dplus_level_select_o},
          {seed[1:0], i[1:0]});
    end
    chk(good_l, 1'b0);
    above_uvlo_i <= 1'b0;
    tick(1);
    chk(good_l, 1'b1);
    above_uvlo_i <= 1'b1;
    charging_i <= 1'b1;
    tick(3);
    chk(state_l, 1'b0);
    charge_done_i <= 1'b1;
    tick(3);
    chk(state_l, 1'b1);
    fault_suspend_i <= 1'b1;
    for (k = 0; state_l !== 1'b0 && k < 100; k = k + 1)
      tick(1);
    for (k = 0; state_l === 1'b0 && k < 100; k = k + 1)
      tick(1);
    chk(k, BLINK);
    for (k = 0; state_l === 1'b1 && k < 100; k = k + 1)
      tick(1);
    chk(k, BLINK);
    wr(`CSPL_REG_CTRL, 8'h02);
    tick(BLINK);
    chk(state_l, 1'b1);
    {charging_i, charge_done_i, fault_suspend_i} <= 3'b000;
    // Two events closer than one pulse must give two separate pulses.
    status_event_i <= 1'b1;
    tick(4);
    status_event_i <= 1'b0;
    tick(4);
    status_event_i <= 1'b1;
    tick(60);
    chk(pulses, 8'h02);
    chk(width, 16'd16);
    rd(`CSPL_REG_EVENT, 8'h02);
    wr(`CSPL_REG_CTRL, 8'h04);
    tick(3);
    chk(battery_switch_on_o, 1'b0);
    press <= 1'b1;
    tick(30);
    press <= 1'b0;
    tick(300);
    chk(battery_switch_on_o, 1'b0);
    press <= 1'b1;
    wait_sw(1'b1);
    press <= 1'b0;
    chk(k >= 200 && k <= 230, 1'b1);
    input_present_i <= 1'b0;
    // Let the debounced button settle high so the long press starts afresh.
    tick(30);
    press <= 1'b1;
    wait_sw(1'b0);
    chk(k >= 400 && k <= 430, 1'b1);
    wait_sw(1'b1);
    chk(k, SW_OFF);
    press <= 1'b0;
    chk(ship_wake_pullup_en_o, 1'b1);
    battery_present_i <= 1'b0;
    tick(1);
    chk(ship_wake_pullup_en_o, 1'b0);
    wrap_up;
  end
endmodule

bind cspl_status_pins cspl_status_pins_monitor #(.ALERT_CYC(ALERT_CYC))
  u_mon (.*);
